// ==== core/nz_core_reset_regs.sv ====
`timescale 1ns/10ps
// Overview of operation
// - Per-channel band enable selects programmed band
// - Band select covers spectrum outside frequency registers
// - Without frequency registers, band covers everything
// - Codes 000, 001, 010 pick bands one-three
// - Reset bit 0-1-0 resets both channels
// - Band settings take effect only on pulse
module nz_core_reset_regs (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [nz_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [nz_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [nz_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [nz_pkg::NUM_CHANNELS-1:0] band_freq_active,
    output logic core_logic_reset_pulse,
    output logic [nz_pkg::NUM_CHANNELS-1:0] applied_band_enable,
    output logic [nz_pkg::NUM_CHANNELS-1:0][2:0] applied_band_zone,
    output logic [nz_pkg::NUM_CHANNELS-1:0][2:0] applied_band_onehot,
    output logic [nz_pkg::NUM_CHANNELS-1:0] zone_covers_all,
    output logic [nz_pkg::NUM_CHANNELS-1:0] zone_covers_rest
);

    localparam int NCH = nz_pkg::NUM_CHANNELS;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        nz_pkg::core_seq_e seq;
        logic pulse;
        logic [nz_pkg::DATA_W-1:0] rdata;
    } ctrl_s;

    ctrl_s state_q;
    ctrl_s state_d;

    logic [NCH-1:0] rst_bits;
    logic [NCH-1:0] pend_en;
    logic [NCH-1:0][2:0] pend_zone;
    logic [NCH-1:0] wr_band;
    logic [NCH-1:0] wr_rst;
    logic any_rst;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    function automatic logic reg_hit(input logic [nz_pkg::ADDR_W-1:0] addr, input logic page,
                                     input logic [7:0] offset);
        return (addr[nz_pkg::PAGE_BIT] == page) && (addr[7:0] == offset);
    endfunction : reg_hit

    // ---------------------------------------------------------------
    // Channel pages
    // ---------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_page
            assign wr_band[gi] = reg_wr && reg_hit(reg_addr, 1'(gi), nz_pkg::OFF_SAMPLING_BAND);
            assign wr_rst[gi] = reg_wr && reg_hit(reg_addr, 1'(gi), nz_pkg::OFF_CORE_RESET);

            nz_channel_page nz_channel_page_i (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .wr_band(wr_band[gi]),
                .wr_core_reset(wr_rst[gi]),
                .wr_data(reg_wdata),
                .commit(state_q.pulse),
                .band_freq_active(band_freq_active[gi]),
                .core_reset_bit(rst_bits[gi]),
                .pend_enable(pend_en[gi]),
                .pend_zone(pend_zone[gi]),
                .applied_enable(applied_band_enable[gi]),
                .applied_zone(applied_band_zone[gi]),
                .applied_onehot(applied_band_onehot[gi]),
                .cover_all(zone_covers_all[gi]),
                .cover_rest(zone_covers_rest[gi])
            );
        end
    endgenerate

    assign any_rst = |rst_bits;

    // ---------------------------------------------------------------
    // Read path and reset sequencer
    // ---------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        state_d.pulse = 1'h0;
        state_d.rdata = '0;
        if (reg_rd) begin
            for (int ch = 0; ch < NCH; ch++) begin
                if (reg_hit(reg_addr, 1'(ch), nz_pkg::OFF_SAMPLING_BAND)) begin
                    // Upper bits read as zero
                    state_d.rdata = {4'h0, pend_en[ch], pend_zone[ch]};
                end
                if (reg_hit(reg_addr, 1'(ch), nz_pkg::OFF_CORE_RESET)) begin
                    state_d.rdata = {7'h00, rst_bits[ch]};
                end
            end
        end
        unique case (state_q.seq)
            nz_pkg::SEQ_LOW: begin
                if (any_rst) begin
                    state_d.seq = nz_pkg::SEQ_HIGH;
                end
            end
            nz_pkg::SEQ_HIGH: begin
                if (!any_rst) begin
                    state_d.seq = nz_pkg::SEQ_LOW;
                    state_d.pulse = 1'h1;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{seq: nz_pkg::SEQ_LOW, pulse: 1'h0, rdata: 8'h00};
        end else begin
            state_q <= state_d;
        end
    end

    assign reg_rdata = state_q.rdata;
    assign core_logic_reset_pulse = state_q.pulse;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_bit_fall;
        any_rst ##1 !any_rst;
    endsequence

    sequence s_band_write_a;
        reg_wr && reg_hit(reg_addr, nz_pkg::PAGE_A, nz_pkg::OFF_SAMPLING_BAND);
    endsequence

    property p_pulse_after_fall;
        s_bit_fall |=> core_logic_reset_pulse;
    endproperty
    a_pulse_after_fall: assert property (p_pulse_after_fall)
        else $error("core reset pulse missing after bit fell");

    property p_pulse_only_after_fall;
        core_logic_reset_pulse |-> !$past(any_rst) && $past(any_rst, 2);
    endproperty
    a_pulse_only_after_fall: assert property (p_pulse_only_after_fall)
        else $error("core reset pulse without a 0-1-0 sequence");

    property p_pulse_single;
        core_logic_reset_pulse |=> !core_logic_reset_pulse;
    endproperty
    a_pulse_single: assert property (p_pulse_single)
        else $error("core reset pulse longer than one cycle");

    property p_band_readback;
        logic [3:0] v;
        (s_band_write_a and (1'h1, v = reg_wdata[3:0])) ##1
            (reg_rd && reg_hit(reg_addr, nz_pkg::PAGE_A, nz_pkg::OFF_SAMPLING_BAND)
             && !reg_wr) |=> reg_rdata == {4'h0, v};
    endproperty
    a_band_readback: assert property (p_band_readback)
        else $error("band register readback mismatch");

    property p_rdata_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside read answer");

    sequence s_band_write_b;
        reg_wr && reg_hit(reg_addr, nz_pkg::PAGE_B, nz_pkg::OFF_SAMPLING_BAND);
    endsequence

    sequence s_band_read_b;
        reg_rd && reg_hit(reg_addr, nz_pkg::PAGE_B, nz_pkg::OFF_SAMPLING_BAND);
    endsequence

    sequence s_reset_write;
        reg_wr && (reg_addr[7:0] == nz_pkg::OFF_CORE_RESET);
    endsequence

    property p_band_readback_b;
        logic [3:0] v;
        (s_band_write_b and (1'h1, v = reg_wdata[3:0])) ##1 s_band_read_b |=>
            reg_rdata == {4'h0, v};
    endproperty
    a_band_readback_b: assert property (p_band_readback_b)
        else $error("channel B band register readback mismatch");

    property p_reset_readback;
        logic pg;
        logic b;
        (s_reset_write, pg = reg_addr[nz_pkg::PAGE_BIT], b = reg_wdata[nz_pkg::BIT_CORE_RESET])
            ##1 (reg_rd && reg_addr == {pg, nz_pkg::OFF_CORE_RESET}) |=>
            reg_rdata == {7'h00, b};
    endproperty
    a_reset_readback: assert property (p_reset_readback)
        else $error("core reset bit readback mismatch");

    property p_either_page_arms;
        (s_reset_write and reg_wdata[nz_pkg::BIT_CORE_RESET]) |=> any_rst;
    endproperty
    a_either_page_arms: assert property (p_either_page_arms)
        else $error("reset bit write on one page did not arm the core reset");

    property p_no_pulse_while_set;
        any_rst |=> !core_logic_reset_pulse;
    endproperty
    a_no_pulse_while_set: assert property (p_no_pulse_while_set)
        else $error("core reset pulse while a reset bit is still set");

    generate
        for (gi = 0; gi < NCH; gi++) begin : g_chk
            property p_commit;
                logic en;
                logic [2:0] z;
                (core_logic_reset_pulse, en = pend_en[gi], z = pend_zone[gi]) |=>
                    applied_band_enable[gi] == en && applied_band_zone[gi] == z;
            endproperty
            a_commit: assert property (p_commit)
                else $error("pending band not committed on core reset pulse");

            property p_hold;
                !core_logic_reset_pulse |=>
                    $stable(applied_band_enable[gi]) && $stable(applied_band_zone[gi]);
            endproperty
            a_hold: assert property (p_hold)
                else $error("applied band changed without core reset pulse");

            property p_common;
                applied_band_enable[gi] && !band_freq_active[gi] |=>
                    zone_covers_all[gi] && !zone_covers_rest[gi];
            endproperty
            a_common: assert property (p_common)
                else $error("band not applied to whole spectrum");

            property p_rest;
                applied_band_enable[gi] && band_freq_active[gi] |=>
                    zone_covers_rest[gi] && !zone_covers_all[gi];
            endproperty
            a_rest: assert property (p_rest)
                else $error("band not limited to uncovered spectrum");

            property p_disabled;
                !applied_band_enable[gi] |=> !zone_covers_all[gi] && !zone_covers_rest[gi]
                    && applied_band_onehot[gi] == 3'h0;
            endproperty
            a_disabled: assert property (p_disabled)
                else $error("band applied while enable is clear");

            property p_encoding;
                applied_band_enable[gi] && applied_band_zone[gi] == nz_pkg::ZONE_SECOND |=>
                    applied_band_onehot[gi] == 3'h2;
            endproperty
            a_encoding: assert property (p_encoding)
                else $error("second band code decoded wrongly");

            property p_encoding_first;
                applied_band_enable[gi] && applied_band_zone[gi] == nz_pkg::ZONE_FIRST |=>
                    applied_band_onehot[gi] == 3'h1;
            endproperty
            a_encoding_first: assert property (p_encoding_first)
                else $error("first band code decoded wrongly");

            property p_encoding_third;
                applied_band_enable[gi] && applied_band_zone[gi] == nz_pkg::ZONE_THIRD |=>
                    applied_band_onehot[gi] == 3'h4;
            endproperty
            a_encoding_third: assert property (p_encoding_third)
                else $error("third band code decoded wrongly");

            property p_encoding_undefined;
                applied_band_zone[gi] > nz_pkg::ZONE_THIRD |=> applied_band_onehot[gi] == 3'h0;
            endproperty
            a_encoding_undefined: assert property (p_encoding_undefined)
                else $error("undefined band code produced a band indicator");
        end
    endgenerate

    property p_independent;
        s_band_write_a |=> $stable(pend_en[1]) && $stable(pend_zone[1]);
    endproperty
    a_independent: assert property (p_independent)
        else $error("channel A write disturbed channel B page");

    property p_independent_b;
        s_band_write_b |=> $stable(pend_en[0]) && $stable(pend_zone[0]);
    endproperty
    a_independent_b: assert property (p_independent_b)
        else $error("channel B write disturbed channel A page");

endmodule : nz_core_reset_regs

// ==== core/nz_pkg.sv ====
package nz_pkg;

    // ---------------------------------------------------------------
    // Register map
    // ---------------------------------------------------------------
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int NUM_CHANNELS = 2;
    // Address bit that selects the channel page: 0 = channel A, 1 = channel B
    localparam int PAGE_BIT = 8;
    localparam logic PAGE_A = 1'h0;
    localparam logic PAGE_B = 1'h1;
    localparam logic [7:0] OFF_CORE_RESET = 8'h00;
    localparam logic [7:0] OFF_SAMPLING_BAND = 8'hA2;

    // ---------------------------------------------------------------
    // Field layout and reset values
    // ---------------------------------------------------------------
    localparam int BIT_CORE_RESET = 0;
    localparam int BIT_BAND_EN = 3;
    localparam int ZONE_LSB = 0;
    localparam int ZONE_W = 3;
    localparam logic RESET_BIT_INIT = 1'h0;
    localparam logic BAND_EN_INIT = 1'h0;
    localparam logic [2:0] ZONE_INIT = 3'h0;

    // ---------------------------------------------------------------
    // Band select encoding
    // ---------------------------------------------------------------
    localparam logic [2:0] ZONE_FIRST = 3'h0;
    localparam logic [2:0] ZONE_SECOND = 3'h1;
    localparam logic [2:0] ZONE_THIRD = 3'h2;

    typedef enum logic {SEQ_LOW, SEQ_HIGH} core_seq_e;

    // One-hot band indicator; zero for codes without a defined band
    function automatic logic [2:0] zone_onehot(input logic [2:0] zone);
        logic [2:0] res;
        res = 3'h0;
        unique case (zone)
            ZONE_FIRST: res = 3'h1;
            ZONE_SECOND: res = 3'h2;
            ZONE_THIRD: res = 3'h4;
            default: res = 3'h0;
        endcase
        return res;
    endfunction : zone_onehot

endpackage : nz_pkg

// ==== core/nz_channel_page.sv ====
`timescale 1ns/10ps
module nz_channel_page (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wr_band,
    input wire logic wr_core_reset,
    input wire logic [7:0] wr_data,
    input wire logic commit,
    input wire logic band_freq_active,
    output logic core_reset_bit,
    output logic pend_enable,
    output logic [2:0] pend_zone,
    output logic applied_enable,
    output logic [2:0] applied_zone,
    output logic [2:0] applied_onehot,
    output logic cover_all,
    output logic cover_rest
);

    typedef struct packed {
        logic rst_bit;
        logic en_pend;
        logic [2:0] zone_pend;
        logic en_app;
        logic [2:0] zone_app;
        logic [2:0] onehot;
        logic cover_all;
        logic cover_rest;
    } page_s;

    page_s state_q;
    page_s state_d;

    always_comb begin
        state_d = state_q;
        if (wr_core_reset) begin
            state_d.rst_bit = wr_data[nz_pkg::BIT_CORE_RESET];
        end
        if (wr_band) begin
            state_d.en_pend = wr_data[nz_pkg::BIT_BAND_EN];
            state_d.zone_pend = wr_data[nz_pkg::ZONE_LSB +: nz_pkg::ZONE_W];
        end
        if (commit) begin
            state_d.en_app = state_q.en_pend;
            state_d.zone_app = state_q.zone_pend;
        end
        state_d.onehot = state_q.en_app ? nz_pkg::zone_onehot(state_q.zone_app) : 3'h0;
        state_d.cover_all = state_q.en_app && !band_freq_active;
        state_d.cover_rest = state_q.en_app && band_freq_active;
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= '{rst_bit: nz_pkg::RESET_BIT_INIT, en_pend: nz_pkg::BAND_EN_INIT,
                         zone_pend: nz_pkg::ZONE_INIT, en_app: nz_pkg::BAND_EN_INIT,
                         zone_app: nz_pkg::ZONE_INIT, onehot: 3'h0,
                         cover_all: 1'h0, cover_rest: 1'h0};
        end else begin
            state_q <= state_d;
        end
    end

    assign core_reset_bit = state_q.rst_bit;
    assign pend_enable = state_q.en_pend;
    assign pend_zone = state_q.zone_pend;
    assign applied_enable = state_q.en_app;
    assign applied_zone = state_q.zone_app;
    assign applied_onehot = state_q.onehot;
    assign cover_all = state_q.cover_all;
    assign cover_rest = state_q.cover_rest;

endmodule : nz_channel_page

// ==== test/test_nz_core_reset_regs.sv ====
`timescale 1ns/10ps
module test_nz_core_reset_regs;

    // ---------------------------------------------------------------
    // Design under test
    // ---------------------------------------------------------------
    logic sys_clk = 1'h0;
    logic reset_n = 1'h0;
    logic [nz_pkg::ADDR_W-1:0] reg_addr = '0;
    logic [nz_pkg::DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [nz_pkg::DATA_W-1:0] reg_rdata;
    logic [1:0] band_freq_active = 2'h0;
    logic core_logic_reset_pulse;
    logic [1:0] applied_band_enable;
    logic [1:0][2:0] applied_band_zone;
    logic [1:0][2:0] applied_band_onehot;
    logic [1:0] zone_covers_all;
    logic [1:0] zone_covers_rest;
    logic [17:0] seen;

    always #50 sys_clk = ~sys_clk;

    nz_core_reset_regs nz_core_reset_regs_i (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .band_freq_active(band_freq_active),
        .core_logic_reset_pulse(core_logic_reset_pulse),
        .applied_band_enable(applied_band_enable),
        .applied_band_zone(applied_band_zone),
        .applied_band_onehot(applied_band_onehot),
        .zone_covers_all(zone_covers_all),
        .zone_covers_rest(zone_covers_rest)
    );

    assign seen = {applied_band_enable, applied_band_zone, applied_band_onehot,
                   zone_covers_all, zone_covers_rest};

    // ---------------------------------------------------------------
    // Reference state and result notes
    // ---------------------------------------------------------------
    logic [1:0] rst_m = 2'h0;
    logic [1:0] en_m = 2'h0;
    logic [1:0][2:0] zn_m = '0;
    logic [17:0] cur = '0;
    logic [17:0] pq[$];
    logic [7:0] rq[$];
    logic rd_d = 1'h0;
    logic [1:0] pd = 2'h0;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;

    function automatic logic [17:0] note();
        logic [1:0][2:0] oh;
        oh = '0;
        for (int c = 0; c < 2; c++) begin
            if (en_m[c] && zn_m[c] == 3'h0) oh[c] = 3'h1;
            if (en_m[c] && zn_m[c] == 3'h1) oh[c] = 3'h2;
            if (en_m[c] && zn_m[c] == 3'h2) oh[c] = 3'h4;
        end
        return {en_m, zn_m, oh, en_m & ~band_freq_active, en_m & band_freq_active};
    endfunction : note

    task automatic check(input logic [17:0] got, input logic [17:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    // ---------------------------------------------------------------
    // Register bus master
    // ---------------------------------------------------------------
    task automatic wr(input logic pg, input logic [7:0] off, input logic [7:0] d);
        logic old;
        old = |rst_m;
        reg_wr <= 1'h1;
        reg_rd <= 1'h0;
        reg_addr <= {pg, off};
        reg_wdata <= d;
        if (off == nz_pkg::OFF_CORE_RESET) rst_m[pg] = d[0];
        if (off == nz_pkg::OFF_SAMPLING_BAND) begin
            en_m[pg] = d[3];
            zn_m[pg] = d[2:0];
        end
        if (old && !(|rst_m)) pq.push_back(note());
        @(posedge sys_clk);
    endtask : wr

    task automatic rd(input logic pg, input logic [7:0] off);
        reg_rd <= 1'h1;
        reg_wr <= 1'h0;
        reg_addr <= {pg, off};
        if (off == nz_pkg::OFF_CORE_RESET) rq.push_back({7'h00, rst_m[pg]});
        else if (off == nz_pkg::OFF_SAMPLING_BAND) rq.push_back({4'h0, en_m[pg], zn_m[pg]});
        else rq.push_back(8'h00);
        @(posedge sys_clk);
    endtask : rd

    task automatic idle(input int n);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        repeat (n) @(posedge sys_clk);
    endtask : idle

    // ---------------------------------------------------------------
    // Output watcher
    // ---------------------------------------------------------------
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 3000) begin
            n_mismatch++;
            finish_test();
        end
        if (rd_d) check({10'h000, reg_rdata}, {10'h000, rq.pop_front()});
        if (pd[1]) begin
            check(seen, pq.pop_front());
            cur = seen;
        end else if (!core_logic_reset_pulse && pd == 2'h0) begin
            check({seen[17:4], 4'h0}, {cur[17:4], 4'h0});
        end
        rd_d = reg_rd && reset_n;
        pd = {pd[0], core_logic_reset_pulse};
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin : main
        logic e;
        logic p;
        logic [2:0] z;
        void'($urandom(32'hDCD1));
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'h1;
        @(posedge sys_clk);
        for (int c = 0; c < 2; c++) begin
            rd(c[0], nz_pkg::OFF_CORE_RESET);
            rd(c[0], nz_pkg::OFF_SAMPLING_BAND);
        end
        rd(1'h0, 8'h55);
        rd(1'h1, 8'hFF);
        wr(1'b0, nz_pkg::OFF_CORE_RESET, 8'h00);
        for (int r = 0; r < 6; r++) begin
            band_freq_active <= 2'($urandom);
            idle(2);
            for (int c = 0; c < 2; c++) begin
                e = (c == 0) ? (r != 5) : 1'($urandom);
                z = (c == 0) ? 3'(r) : 3'($urandom);
                wr(c[0], nz_pkg::OFF_SAMPLING_BAND, {4'h0, e, 3'h0});
                wr(c[0], nz_pkg::OFF_SAMPLING_BAND, {4'($urandom), e, z});
                rd(c[0], nz_pkg::OFF_SAMPLING_BAND);
            end
            idle(3);
            p = r[0];
            wr(p, nz_pkg::OFF_CORE_RESET, 8'h01);
            if (r[1]) wr(!p, nz_pkg::OFF_CORE_RESET, 8'hFF);
            rd(p, nz_pkg::OFF_CORE_RESET);
            wr(!p, nz_pkg::OFF_CORE_RESET, 8'h00);
            wr(p, nz_pkg::OFF_CORE_RESET, 8'h00);
            idle(6);
        end
        idle(4);
        finish_test();
    end

endmodule : test_nz_core_reset_regs
